// [logic/ep0_tx_pkg.sv]
// ep0_tx_pkg: register map, field positions and carrier types
// assumes a 32-bit apb slave with word-aligned registers
package ep0_tx_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] count_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;

  // ****************************************
  // field positions
  // ****************************************
  localparam int flush_bit = 7;
  localparam int stall_bit = 3;
  localparam int armed_bit = 1;
  localparam int enable_bit = 0;
  localparam int count_width = 4;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [3:0] count_reset = 4'h0;
  localparam logic [31:0] zero_word = 32'h0000_0000;
  // flush completes after this many cycles of pointer reset
  localparam logic [1:0] flush_cycles = 2'h2;

  // ****************************************
  // handshake encodings
  // ****************************************
  typedef enum logic [1:0] {
    hs_none = 2'b00,
    hs_data = 2'b01,
    hs_nak = 2'b10,
    hs_stall = 2'b11
  } handshake_t;

  // usb-side events from the serial engine
  typedef struct packed {
    logic in_token;
    logic setup_ok;
    logic host_ack;
  } usb_event_t;

  // fifo reset commands toward the fifo
  typedef struct packed {
    logic ptr_reset;
    logic flags_set_empty;
  } fifo_cmd_t;

endpackage : ep0_tx_pkg

// [logic/ep0_flush_seq.sv]
// ep0_flush_seq: times the fifo pointer reset started by a flush
// assumes start is the control register flush bit, held high until done
`timescale 1ns/1ps
module ep0_flush_seq (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  output ep0_tx_pkg::fifo_cmd_t cmd,
  output logic done
);

  // ****************************************
  // pointer reset timer
  // ****************************************
  logic [1:0] count_reg;
  logic busy_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (start && !busy_reg) begin
      busy_reg <= 1'b1;
      count_reg <= ep0_tx_pkg::flush_cycles;
    end else if (busy_reg) begin
      count_reg <= count_reg - 2'h1;
      if (count_reg == 2'h1) begin
        busy_reg <= 1'b0;
      end
    end
  end

  assign cmd.ptr_reset = busy_reg;
  assign cmd.flags_set_empty = busy_reg && (count_reg == 2'h1);
  assign done = busy_reg && (count_reg == 2'h1);

endmodule : ep0_flush_seq

// [logic/ep0_tx_control.sv]
// ep0_tx_control: endpoint 0 transmit control register and
// in-transaction handshake choice, reached over apb
// assumes usb events are one-cycle pulses synchronous to pclk
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module ep0_tx_control (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // usb side
  input wire ep0_tx_pkg::usb_event_t usb_ev,
  input wire logic rx_enable,
  output ep0_tx_pkg::handshake_t handshake,
  output logic [3:0] tx_byte_count,
  // fifo and function port
  output ep0_tx_pkg::fifo_cmd_t fifo_cmd,
  output logic ack_status,
  output logic port_connect
);

  // ****************************************
  // decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  logic wr_en;
  logic rd_en;
  logic flush_reg;
  logic stall_request_reg;
  logic fifo_armed_reg;
  logic endpoint_enable_reg;
  logic [3:0] count_reg;
  logic ack_reg;
  logic flush_done;
  logic flush_start;
  ep0_tx_pkg::handshake_t hs_next;
  ep0_tx_pkg::handshake_t hs_reg;
  logic [7:0] ctrl_view;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign flush_start = flush_reg;

  // ****************************************
  // flush sequencer
  // ****************************************
  ep0_flush_seq u_flush (
    .pclk(pclk),
    .presetn(presetn),
    .start(flush_start),
    .cmd(fifo_cmd),
    .done(flush_done)
  );

  // ****************************************
  // control bits
  // ****************************************
  // flush set and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_reg <= 1'b0;
    end else if (wr_en && hit(paddr, ep0_tx_pkg::ctrl_off)
                 && pwdata[ep0_tx_pkg::flush_bit]) begin
      flush_reg <= 1'b1;
    end else if (flush_done) begin
      flush_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_request_reg <= 1'b0;
    end else if (usb_ev.setup_ok) begin
      stall_request_reg <= 1'b0;
    end else if (wr_en && hit(paddr, ep0_tx_pkg::ctrl_off)) begin
      stall_request_reg <= pwdata[ep0_tx_pkg::stall_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_armed_reg <= 1'b0;
    end else if (usb_ev.setup_ok || flush_reg
                 || (wr_en && hit(paddr, ep0_tx_pkg::ctrl_off)
                     && pwdata[ep0_tx_pkg::flush_bit])) begin
      fifo_armed_reg <= 1'b0;
    end else if (wr_en && hit(paddr, ep0_tx_pkg::count_off)) begin
      fifo_armed_reg <= 1'b1;
    end else if (hs_reg == ep0_tx_pkg::hs_data && usb_ev.host_ack) begin
      fifo_armed_reg <= 1'b0;
    end else if (wr_en && hit(paddr, ep0_tx_pkg::ctrl_off)) begin
      fifo_armed_reg <= pwdata[ep0_tx_pkg::armed_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endpoint_enable_reg <= 1'b0;
    end else if (wr_en && hit(paddr, ep0_tx_pkg::ctrl_off)) begin
      endpoint_enable_reg <= pwdata[ep0_tx_pkg::enable_bit];
    end
  end

  // byte count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= ep0_tx_pkg::count_reset;
    end else if (wr_en && hit(paddr, ep0_tx_pkg::count_off)) begin
      count_reg <= pwdata[ep0_tx_pkg::count_width-1:0];
    end
  end

  // ack status; host ack sets, write of one clears, setup clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else if (hs_reg == ep0_tx_pkg::hs_data && usb_ev.host_ack) begin
      ack_reg <= 1'b1;
    end else if (usb_ev.setup_ok) begin
      ack_reg <= 1'b0;
    end else if (wr_en && hit(paddr, ep0_tx_pkg::status_off)
                 && pwdata[0]) begin
      ack_reg <= 1'b0;
    end
  end

  // ****************************************
  // handshake choice
  // ****************************************
  // priority: stall, data, nak
  always_comb begin
    hs_next = hs_reg;
    if (usb_ev.in_token && endpoint_enable_reg) begin
      if (stall_request_reg) begin
        hs_next = ep0_tx_pkg::hs_stall;
      end else if (fifo_armed_reg) begin
        hs_next = ep0_tx_pkg::hs_data;
      end else begin
        hs_next = ep0_tx_pkg::hs_nak;
      end
    end else if (usb_ev.in_token) begin
      hs_next = ep0_tx_pkg::hs_none;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_reg <= ep0_tx_pkg::hs_none;
    end else begin
      hs_reg <= hs_next;
    end
  end

  // ****************************************
  // outputs and read data
  // ****************************************
  assign handshake = hs_reg;
  assign tx_byte_count = count_reg;
  assign ack_status = ack_reg;
  assign port_connect = endpoint_enable_reg && rx_enable;

  always_comb begin
    ctrl_view = ep0_tx_pkg::ctrl_reset;
    ctrl_view[ep0_tx_pkg::flush_bit] = flush_reg;
    ctrl_view[ep0_tx_pkg::stall_bit] = stall_request_reg;
    ctrl_view[ep0_tx_pkg::armed_bit] = fifo_armed_reg;
    ctrl_view[ep0_tx_pkg::enable_bit] = endpoint_enable_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ep0_tx_pkg::zero_word;
    end else if (rd_en && !penable) begin
      if (hit(paddr, ep0_tx_pkg::ctrl_off)) begin
        prdata <= {24'h00_0000, ctrl_view};
      end else if (hit(paddr, ep0_tx_pkg::count_off)) begin
        prdata <= {28'h000_0000, count_reg};
      end else if (hit(paddr, ep0_tx_pkg::status_off)) begin
        prdata <= {31'h0000_0000, ack_reg};
      end else begin
        prdata <= ep0_tx_pkg::zero_word;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  stall_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    usb_ev.in_token && endpoint_enable_reg && stall_request_reg
    |=> handshake == ep0_tx_pkg::hs_stall)
    else $error("stall not returned");
  nak_unarmed_a: assert property (@(posedge pclk) disable iff (!presetn)
    usb_ev.in_token && endpoint_enable_reg && !stall_request_reg
    && !fifo_armed_reg |=> handshake == ep0_tx_pkg::hs_nak)
    else $error("nak not returned");
  data_armed_a: assert property (@(posedge pclk) disable iff (!presetn)
    usb_ev.in_token && endpoint_enable_reg && !stall_request_reg
    && fifo_armed_reg |=> handshake == ep0_tx_pkg::hs_data)
    else $error("data not sent");
  setup_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    usb_ev.setup_ok |=> !stall_request_reg && !fifo_armed_reg)
    else $error("setup did not clear");
  count_arms_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, ep0_tx_pkg::count_off) && !usb_ev.setup_ok
    && !flush_reg && !pwdata[ep0_tx_pkg::flush_bit]
    |=> fifo_armed_reg)
    else $error("count write did not arm");
  flush_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flush_reg) |-> ##[1:4] !flush_reg)
    else $error("flush did not self clear");
  flush_disarms_a: assert property (@(posedge pclk) disable iff (!presetn)
    flush_reg |=> !fifo_armed_reg)
    else $error("flush did not disarm");
  connect_both_a: assert property (@(posedge pclk) disable iff (!presetn)
    port_connect |-> endpoint_enable_reg && rx_enable)
    else $error("connect without enables");
  ack_disarms_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ack_reg) |-> !fifo_armed_reg)
    else $error("ack did not disarm");
  flush_starts_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, ep0_tx_pkg::ctrl_off)
    && pwdata[ep0_tx_pkg::flush_bit] |=> flush_reg)
    else $error("flush write not taken");
  flush_ptr_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flush_reg) |=> fifo_cmd.ptr_reset)
    else $error("pointer reset missing");
  flush_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_cmd.flags_set_empty && !wr_en |=> !flush_reg)
    else $error("flush bit stuck after empty");
  ack_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    handshake == ep0_tx_pkg::hs_data && usb_ev.host_ack
    |=> ack_status)
    else $error("ack status not set");
  ack_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, ep0_tx_pkg::status_off) && pwdata[0]
    && !usb_ev.host_ack |=> !ack_status)
    else $error("ack status not cleared");
  disabled_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    usb_ev.in_token && !endpoint_enable_reg
    |=> handshake == ep0_tx_pkg::hs_none)
    else $error("disabled endpoint answered");
  hs_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    !usb_ev.in_token |=> $stable(handshake))
    else $error("handshake changed without token");
  stall_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, ep0_tx_pkg::ctrl_off) && !usb_ev.setup_ok
    && pwdata[ep0_tx_pkg::stall_bit] |=> stall_request_reg)
    else $error("stall bit not written");
  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, ep0_tx_pkg::ctrl_off)
    && pwdata[ep0_tx_pkg::enable_bit] |=> endpoint_enable_reg)
    else $error("enable bit not written");
  armed_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, ep0_tx_pkg::ctrl_off) && !flush_reg
    && pwdata[ep0_tx_pkg::armed_bit] && !pwdata[ep0_tx_pkg::flush_bit]
    && !usb_ev.setup_ok && !usb_ev.host_ack |=> fifo_armed_reg)
    else $error("armed bit not written");

endmodule : ep0_tx_control

// [bench/usb_host_model.sv]
// usb_host_model: far-side host that sends tokens and acks data
// assumes bench requests are one-cycle pulses after pclk edges
`timescale 1ns/1ps
module usb_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench requests
  input wire logic send_in,
  input wire logic send_setup,
  input wire logic ack_ok,
  // device side
  input wire ep0_tx_pkg::handshake_t handshake,
  output ep0_tx_pkg::usb_event_t usb_ev
);
  // ****************************************
  // token and ack generation
  // ****************************************
  logic [1:0] wait_reg;
  logic ack_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 2'h0;
      ack_reg <= 1'b0;
    end else begin
      wait_reg <= {wait_reg[0], send_in};
      ack_reg <= wait_reg[1] & ack_ok &
        (handshake == ep0_tx_pkg::hs_data);
    end
  end
  assign usb_ev = {send_in, send_setup, ack_reg};
endmodule : usb_host_model

// [bench/ep0_tx_control_test.sv]
// ep0_tx_control_test: apb and usb stimulus with a model
// assumes zero-wait apb slave and a 125 MHz pclk
`timescale 1ns/1ps
module ep0_tx_control_test;
  // ****************************************
  // signals and instances
  // ****************************************
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rx_enable = 1'b0, send_in = 1'b0;
  logic send_setup = 1'b0, ack_ok = 1'b1, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, c;
  logic [31:0] rnd = 32'h0000_9F48;
  ep0_tx_pkg::usb_event_t usb_ev;
  ep0_tx_pkg::handshake_t handshake;
  ep0_tx_pkg::fifo_cmd_t fifo_cmd;
  logic [3:0] tx_byte_count;
  logic ack_status, port_connect;
  int failures = 0, tests_run = 0, m_ctrl = 0, np, ne;
  always #4 pclk = ~pclk;
  ep0_tx_control ep0_tx_control_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_ev(usb_ev), .rx_enable(rx_enable),
    .handshake(handshake), .tx_byte_count(tx_byte_count),
    .fifo_cmd(fifo_cmd), .ack_status(ack_status),
    .port_connect(port_connect));
  usb_host_model usb_host_model_inst (.pclk(pclk), .presetn(presetn),
    .send_in(send_in), .send_setup(send_setup), .ack_ok(ack_ok),
    .handshake(handshake), .usb_ev(usb_ev));
  // ****************************************
  // tasks and model
  // ****************************************
  function logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tally_and_finish();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      tally_and_finish();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rd
  task usb(input logic s);
    if (s)
      send_setup <= 1'b1;
    else
      send_in <= 1'b1;
    @(posedge pclk);
    send_setup <= 1'b0;
    send_in <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : usb
  task do_in();
    logic [1:0] e;
    e = !m_ctrl[0] ? 2'b00 : m_ctrl[3] ? 2'b11 : m_ctrl[1] ? 2'b01 : 2'b10;
    usb(1'b0);
    check(handshake, e);
    if (e == 2'b01)
      m_ctrl = m_ctrl & 32'hFFFF_FFFD;
    check(ack_status, e == 2'b01);
  endtask : do_in
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ep0_tx_pkg::ctrl_off, 32'h0000_0000);
    rd(ep0_tx_pkg::status_off, 32'h0000_0000);
    c = xs();
    rx_enable <= c[0];
    apb(1'b1, ep0_tx_pkg::ctrl_off, 32'h0000_007F);
    m_ctrl = 32'h0000_000B;
    rd(ep0_tx_pkg::ctrl_off, m_ctrl);
    check(port_connect, c[0]);
    do_in();
    usb(1'b1);
    m_ctrl = 1;
    rd(ep0_tx_pkg::ctrl_off, m_ctrl);
    do_in();
    apb(1'b1, ep0_tx_pkg::ctrl_off, 32'h0000_0009);
    m_ctrl = 9;
    do_in();
    usb(1'b1);
    m_ctrl = 1;
    c = xs() & 32'h0000_000F;
    apb(1'b1, ep0_tx_pkg::count_off, c);
    m_ctrl = 3;
    rd(ep0_tx_pkg::ctrl_off, m_ctrl);
    check(tx_byte_count, c);
    do_in();
    rd(ep0_tx_pkg::ctrl_off, m_ctrl);
    rd(ep0_tx_pkg::status_off, 32'h0000_0001);
    apb(1'b1, ep0_tx_pkg::status_off, 32'h0000_0001);
    rd(ep0_tx_pkg::status_off, 32'h0000_0000);
    apb(1'b1, ep0_tx_pkg::count_off, c);
    apb(1'b1, ep0_tx_pkg::ctrl_off, 32'h0000_0083);
    np = 0;
    ne = 0;
    repeat (10) begin
      @(posedge pclk);
      np += fifo_cmd.ptr_reset;
      ne += fifo_cmd.flags_set_empty;
    end
    check(np, ep0_tx_pkg::flush_cycles);
    check(ne, 1);
    rd(ep0_tx_pkg::ctrl_off, m_ctrl & 32'h0000_0001);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000);
    check(pslverr, 1'b0);
    rx_enable <= 1'b1;
    apb(1'b1, ep0_tx_pkg::ctrl_off, 32'h0000_0000);
    m_ctrl = 0;
    check(port_connect, 1'b0);
    do_in();
    tally_and_finish();
  end
endmodule : ep0_tx_control_test
